/* hw/umsp_pkg.sv */
// constants, field layout and carrier types of the serial port block
package umsp_pkg;

    // ---------------------------------------------------------------
    // register word index on the bus (byte address = index * 4)
    // ---------------------------------------------------------------
    localparam int AVS_AW = 3;
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_BAUD = 3'h1;
    localparam logic [2:0] REG_RX = 3'h2;
    localparam logic [2:0] REG_TX = 3'h3;
    localparam logic [2:0] REG_FLOW = 3'h4;

    // ---------------------------------------------------------------
    // control register bits
    // ---------------------------------------------------------------
    localparam int C_UART_EN = 0;
    localparam int C_RX_EN = 1;
    localparam int C_TX_EN = 2;
    localparam int C_CLK1X = 3;
    localparam int C_PAR_EN = 4;
    localparam int C_ODD = 5;
    localparam int C_EIGHT = 6;
    localparam int C_IR = 7;
    localparam int C_IR_INV = 8;
    localparam int C_IGN_FLOW = 9;
    localparam int C_BREAK = 10;
    localparam int C_CTS_IRQ = 11;
    localparam int C_GPIO_IRQ = 12;
    localparam logic [15:0] CTRL_RST = 16'h0000;

    // ---------------------------------------------------------------
    // baud control register: prescale, tap, gpio roles
    // ---------------------------------------------------------------
    localparam int B_PRE_LO = 0;
    localparam int B_TAP_LO = 8;
    localparam int B_SRC_GPIO = 11;
    localparam int B_GPIO_OE = 12;
    localparam int B_GPIO_CLK = 13;
    localparam int B_AUX_LVL = 14;
    localparam logic [15:0] BAUD_RST = 16'h0000;

    // ---------------------------------------------------------------
    // receive word, transmit status and flow register bits
    // ---------------------------------------------------------------
    localparam int RX_PERR = 8;
    localparam int RX_FERR = 9;
    localparam int RX_BRK = 10;
    localparam int RX_OVR = 11;
    localparam int RX_VALID = 12;
    localparam int RX_HALF = 13;
    localparam int RX_RTS_SW = 14;
    localparam int RX_RTS_LVL = 15;
    localparam int TX_AVAIL = 0;
    localparam int TX_EMPTY = 1;
    localparam int TX_BUSY = 2;
    localparam int F_CTS_LVL = 0;
    localparam int F_CTS_DELTA = 1;
    localparam int F_GPIO_LVL = 2;
    localparam int F_GPIO_DELTA = 3;

    // ---------------------------------------------------------------
    // synchroniser slots, fifo and bit timing
    // ---------------------------------------------------------------
    localparam int PIN_RXD = 0;
    localparam int PIN_CTS = 1;
    localparam int PIN_GPIO = 2;
    localparam int FIFO_AW = 3;
    localparam logic [3:0] FIFO_DEPTH = 4'h8;
    localparam logic [3:0] FIFO_HALF = 4'h4;
    localparam int RX_EW = 11;
    localparam logic [3:0] PH_LAST = 4'hf;
    localparam logic [3:0] PH_VOTE_LO = 4'h6;
    localparam logic [3:0] PH_VOTE_HI = 4'h8;
    localparam logic [3:0] IR_PULSE_PH = 4'h3;
    localparam logic [2:0] LAST_BIT8 = 3'h7;
    localparam logic [2:0] LAST_BIT7 = 3'h6;
    localparam logic [1:0] VOTE_MAJ = 2'h2;

    // frame sequencer states, gray along the frame
    typedef enum logic [2:0] {
        FS_IDLE = 3'b000,
        FS_START = 3'b001,
        FS_DATA = 3'b011,
        FS_PAR = 3'b010,
        FS_STOP = 3'b110
    } umsp_fstate_t;

    // avalon request and answer
    typedef struct packed {
        logic read;
        logic write;
        logic [AVS_AW-1:0] address;
        logic [31:0] writedata;
    } umsp_avs_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } umsp_avs_rsp_t;

endpackage : umsp_pkg

/* hw/umsp_uart.sv */
// serial port: framing, infra-red coding, flow pins, fifos, avalon registers
//
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ns
module umsp_uart (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire umsp_pkg::umsp_avs_req_t avs_req_i,
    output umsp_pkg::umsp_avs_rsp_t avs_rsp_o,
    input wire logic rxd_i,
    input wire logic cts_n_i,
    input wire logic gpio_i,
    output logic txd_o,
    output logic rts_n_o,
    output logic gpio_o,
    output logic gpio_oe_o,
    output logic event_req_o
);
    import umsp_pkg::*;

    // ---------------------------------------------------------------
    // state record
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [2:0] sy1;
        logic [2:0] sy2;
        logic [2:0] sy3;
        logic [2:0] lvl;
        logic [1:0] warm;
        logic [15:0] ctrl;
        logic [15:0] baud;
        logic rts_sw;
        logic rts_lvl;
        logic cts_delta;
        logic gpio_delta;
        logic overrun;
        logic [7:0] pre_cnt;
        logic [7:0] tap_cnt;
        logic [3:0] ph16;
        logic [7:0][7:0] tmem;
        logic [FIFO_AW-1:0] twp;
        logic [FIFO_AW-1:0] trp;
        logic [3:0] tcnt;
        umsp_fstate_t tst;
        logic [7:0] tsh;
        logic [2:0] tbit;
        logic tpar;
        logic [7:0][RX_EW-1:0] rmem;
        logic [FIFO_AW-1:0] rwp;
        logic [FIFO_AW-1:0] rrp;
        logic [3:0] rcnt;
        umsp_fstate_t rst;
        logic [3:0] rph;
        logic [1:0] vote;
        logic pseen;
        logic [7:0] rsh;
        logic [2:0] rbit;
        logic rpar;
        logic rperr;
        umsp_avs_rsp_t rsp;
        logic txd;
        logic rts_n;
        logic gpio_o;
        logic gpio_oe;
        logic evt;
    } umsp_state_t;

    umsp_state_t s;
    umsp_state_t next_s;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        logic base_tick;
        logic pre_tick;
        logic tick16;
        logic tick1;
        logic [7:0] tap_mask;
        logic x1;
        logic ir;
        logic inv;
        logic req;
        logic commit;
        logic tpush;
        logic tpop;
        logic rpush;
        logic rpop;
        logic tbitval;
        logic tzero;
        logic [2:0] tlast;
        logic [2:0] rlast;
        logic [7:0] tdata;
        logic [7:0] rdata;
        logic rz;
        logic bit_done;
        logic rb;
        base_tick = 1'b0;
        pre_tick = 1'b0;
        tick16 = 1'b0;
        tick1 = 1'b0;
        tpush = 1'b0;
        tpop = 1'b0;
        rpush = 1'b0;
        rpop = 1'b0;
        tbitval = 1'b1;
        rb = 1'b1;
        tdata = s.tmem[s.trp];
        rdata = s.ctrl[C_EIGHT] ? s.rsh : {1'b0, s.rsh[7:1]};
        next_s = s;
        x1 = s.ctrl[C_CLK1X];
        ir = s.ctrl[C_IR];
        inv = s.ctrl[C_IR_INV];
        tlast = s.ctrl[C_EIGHT] ? LAST_BIT8 : LAST_BIT7;
        rlast = tlast;

        // three-stage pin synchronisers; level moves once stages 2 and 3 agree
        next_s.sy1 = {gpio_i, cts_n_i, rxd_i};
        next_s.sy2 = s.sy1;
        next_s.sy3 = s.sy2;
        next_s.lvl = (s.sy2 & s.sy3) | (s.lvl & (s.sy2 ^ s.sy3));
        // after reset the levels follow stage 2 for the first three cycles, so no false edge follows
        next_s.warm = s.warm + {1'b0, ~(&s.warm)};
        if (!(&s.warm)) begin
            next_s.lvl = s.sy2;
        end

        // bus: answer one cycle after the request is seen
        req = avs_req_i.read | avs_req_i.write;
        commit = req & ~s.rsp.waitrequest;
        next_s.rsp.waitrequest = ~(req & s.rsp.waitrequest);
        if (req && s.rsp.waitrequest) begin
            next_s.rsp.readdata = '0;
            case (avs_req_i.address)
                REG_CTRL: next_s.rsp.readdata[15:0] = s.ctrl;
                REG_BAUD: next_s.rsp.readdata[15:0] = s.baud;
                REG_RX: begin
                    if (s.rcnt != 4'h0) begin
                        next_s.rsp.readdata[RX_EW-1:0] = s.rmem[s.rrp];
                    end
                    next_s.rsp.readdata[RX_OVR] = s.overrun;
                    next_s.rsp.readdata[RX_VALID] = (s.rcnt != 4'h0);
                    next_s.rsp.readdata[RX_HALF] = (s.rcnt >= FIFO_HALF);
                    next_s.rsp.readdata[RX_RTS_SW] = s.rts_sw;
                    next_s.rsp.readdata[RX_RTS_LVL] = s.rts_lvl;
                end
                REG_TX: begin
                    next_s.rsp.readdata[TX_AVAIL] = (s.tcnt != FIFO_DEPTH);
                    next_s.rsp.readdata[TX_EMPTY] = (s.tcnt == 4'h0);
                    next_s.rsp.readdata[TX_BUSY] = (s.tst != FS_IDLE);
                end
                REG_FLOW: begin
                    next_s.rsp.readdata[F_CTS_LVL] = s.lvl[PIN_CTS];
                    next_s.rsp.readdata[F_CTS_DELTA] = s.cts_delta;
                    next_s.rsp.readdata[F_GPIO_LVL] = s.lvl[PIN_GPIO];
                    next_s.rsp.readdata[F_GPIO_DELTA] = s.gpio_delta;
                end
                default: next_s.rsp.readdata = '0;
            endcase
        end

        // register writes; flag clears come before the edge sets below
        if (commit && avs_req_i.write) begin
            case (avs_req_i.address)
                REG_CTRL: next_s.ctrl = avs_req_i.writedata[15:0];
                REG_BAUD: next_s.baud = avs_req_i.writedata[15:0];
                REG_RX: begin
                    next_s.rts_sw = avs_req_i.writedata[RX_RTS_SW];
                    next_s.rts_lvl = avs_req_i.writedata[RX_RTS_LVL];
                end
                REG_TX: tpush = (s.tcnt != FIFO_DEPTH);
                REG_FLOW: begin
                    if (avs_req_i.writedata[F_CTS_DELTA]) begin
                        next_s.cts_delta = 1'b0;
                    end
                    if (avs_req_i.writedata[F_GPIO_DELTA]) begin
                        next_s.gpio_delta = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // a read of the receive word consumes the entry it returned
        if (commit && avs_req_i.read && avs_req_i.address == REG_RX) begin
            rpop = s.rsp.readdata[RX_VALID];
            next_s.overrun = 1'b0;
        end

        // pin edge events, set wins over a clear in the same cycle
        if (&s.warm && s.lvl[PIN_CTS] != next_s.lvl[PIN_CTS]) begin
            next_s.cts_delta = 1'b1;
        end
        if (&s.warm && !s.baud[B_GPIO_OE] && s.lvl[PIN_GPIO] != next_s.lvl[PIN_GPIO]) begin
            next_s.gpio_delta = 1'b1;
        end
        next_s.evt = (next_s.cts_delta & s.ctrl[C_CTS_IRQ])
            | (next_s.gpio_delta & s.ctrl[C_GPIO_IRQ]);

        // baud generator: source, prescaler, binary tap
        if (s.ctrl[C_UART_EN]) begin
            base_tick = s.baud[B_SRC_GPIO] ?
                (next_s.lvl[PIN_GPIO] & ~s.lvl[PIN_GPIO]) : 1'b1;
        end
        if (base_tick) begin
            pre_tick = (s.pre_cnt == 8'h00);
            next_s.pre_cnt = pre_tick ? s.baud[B_PRE_LO +: 8] : s.pre_cnt - 8'h01;
        end
        tap_mask = (8'h01 << s.baud[B_TAP_LO +: 3]) - 8'h01;
        if (pre_tick) begin
            tick16 = ((s.tap_cnt | ~tap_mask) == 8'hff);
            next_s.tap_cnt = s.tap_cnt + 8'h01;
        end
        if (tick16) begin
            next_s.ph16 = s.ph16 + 4'h1;
        end
        // bit clock: sixteenth of the 16x clock, or the 16x clock itself in 1x mode
        tick1 = x1 ? tick16 : (tick16 && s.ph16 == PH_LAST);

        // transmitter sequencer, moves only on bit clock edges
        case (s.tst)
            FS_IDLE: begin
                if (tick1 && s.ctrl[C_TX_EN] && s.tcnt != 4'h0
                    && (s.ctrl[C_IGN_FLOW] || !s.lvl[PIN_CTS])) begin
                    tpop = 1'b1;
                    next_s.tsh = tdata;
                    next_s.tpar = s.ctrl[C_ODD] ^ (s.ctrl[C_EIGHT] ? ^tdata : ^tdata[6:0]);
                    next_s.tst = FS_START;
                end
            end
            FS_START: begin
                tbitval = 1'b0;
                if (tick1) begin
                    next_s.tbit = 3'h0;
                    next_s.tst = FS_DATA;
                end
            end
            FS_DATA: begin
                tbitval = s.tsh[0];
                if (tick1) begin
                    next_s.tsh = {1'b0, s.tsh[7:1]};
                    next_s.tbit = s.tbit + 3'h1;
                    if (s.tbit == tlast) begin
                        next_s.tst = s.ctrl[C_PAR_EN] ? FS_PAR : FS_STOP;
                    end
                end
            end
            FS_PAR: begin
                tbitval = s.tpar;
                if (tick1) begin
                    next_s.tst = FS_STOP;
                end
            end
            FS_STOP: begin
                tbitval = 1'b1;
                if (tick1) begin
                    next_s.tst = FS_IDLE;
                end
            end
            default: next_s.tst = FS_IDLE;
        endcase
        if (s.ctrl[C_BREAK]) begin
            tbitval = 1'b0;
        end
        // line coding: nrz level, or a 3/16 pulse per zero bit
        tzero = ~tbitval;
        next_s.txd = ir ? ((tzero && s.ph16 < IR_PULSE_PH) ^ inv) : tbitval;

        // receiver: zero-bit sense from nrz low or an infra-red pulse
        rz = ir ? (s.lvl[PIN_RXD] ^ inv) : ~s.lvl[PIN_RXD];
        bit_done = 1'b0;
        if (tick16 && s.ctrl[C_RX_EN] && s.rst != FS_IDLE) begin
            next_s.rph = s.rph + 4'h1;
            next_s.pseen = s.pseen | rz;
            if (s.rph >= PH_VOTE_LO && s.rph <= PH_VOTE_HI && rz) begin
                next_s.vote = s.vote + 2'h1;
            end
            bit_done = x1 || s.rph == PH_LAST;
            if (x1) begin
                rb = ~rz;
            end else if (ir) begin
                rb = ~(s.pseen | rz);
            end else begin
                rb = (s.vote < VOTE_MAJ);
            end
            if (bit_done) begin
                next_s.rph = 4'h0;
                next_s.vote = 2'h0;
                next_s.pseen = 1'b0;
            end
        end
        case (s.rst)
            FS_IDLE: begin
                if (tick16 && s.ctrl[C_RX_EN] && rz) begin
                    next_s.rph = 4'h1;
                    next_s.vote = 2'h0;
                    next_s.pseen = 1'b1;
                    next_s.rpar = 1'b0;
                    next_s.rbit = 3'h0;
                    next_s.rst = x1 ? FS_DATA : FS_START;
                end
            end
            FS_START: begin
                if (bit_done) begin
                    next_s.rst = rb ? FS_IDLE : FS_DATA; // false start drops back
                end
            end
            FS_DATA: begin
                if (bit_done) begin
                    next_s.rsh = {rb, s.rsh[7:1]};
                    next_s.rpar = s.rpar ^ rb;
                    next_s.rbit = s.rbit + 3'h1;
                    if (s.rbit == rlast) begin
                        next_s.rst = s.ctrl[C_PAR_EN] ? FS_PAR : FS_STOP;
                    end
                end
            end
            FS_PAR: begin
                if (bit_done) begin
                    next_s.rperr = (s.rpar ^ rb) != s.ctrl[C_ODD];
                    next_s.rpar = s.rpar ^ rb;
                    next_s.rst = FS_STOP;
                end
            end
            FS_STOP: begin
                if (bit_done) begin
                    next_s.rst = FS_IDLE;
                    if (s.rcnt == FIFO_DEPTH) begin
                        next_s.overrun = 1'b1;
                    end else begin
                        rpush = 1'b1;
                        next_s.rmem[s.rwp] = {~rb && rdata == 8'h00 && !s.rpar,
                                              ~rb,
                                              s.rperr & s.ctrl[C_PAR_EN], rdata};
                    end
                    next_s.rperr = 1'b0;
                end
            end
            default: next_s.rst = FS_IDLE;
        endcase

        // fifo pointers and counts
        if (tpush) begin
            next_s.tmem[s.twp] = avs_req_i.writedata[7:0];
            next_s.twp = s.twp + 3'h1;
        end
        if (tpop) begin
            next_s.trp = s.trp + 3'h1;
        end
        next_s.tcnt = s.tcnt + {3'h0, tpush} - {3'h0, tpop};
        if (rpush) begin
            next_s.rwp = s.rwp + 3'h1;
        end
        if (rpop) begin
            next_s.rrp = s.rrp + 3'h1;
        end
        next_s.rcnt = s.rcnt + {3'h0, rpush} - {3'h0, rpop};

        // flow and auxiliary pins
        if (s.rts_sw) begin
            next_s.rts_n = s.rts_lvl;
        end else begin
            next_s.rts_n = (next_s.rcnt == FIFO_DEPTH);
        end
        next_s.gpio_oe = s.baud[B_GPIO_OE];
        if (s.baud[B_GPIO_CLK]) begin
            next_s.gpio_o = x1 ? s.ph16[0] : s.ph16[3];
        end else begin
            next_s.gpio_o = s.baud[B_AUX_LVL];
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s <= '0;
            s.ctrl <= CTRL_RST;
            s.baud <= BAUD_RST;
            s.sy1 <= 3'h7;
            s.sy2 <= 3'h7;
            s.sy3 <= 3'h7;
            s.lvl <= 3'h7;
            s.tst <= FS_IDLE;
            s.rst <= FS_IDLE;
            s.rsp.waitrequest <= 1'b1;
            s.txd <= 1'b1;
            s.rts_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state record
    assign avs_rsp_o = s.rsp;
    assign txd_o = s.txd;
    assign rts_n_o = s.rts_n;
    assign gpio_o = s.gpio_o;
    assign gpio_oe_o = s.gpio_oe;
    assign event_req_o = s.evt;

endmodule : umsp_uart

/* bench/umsp_far_end.sv */
// far-side serial partner: echoes frames back or holds a break
`timescale 1ns/1ns
module umsp_far_end (
    input wire logic txd_i,
    input wire logic brk_i,
    output logic rxd_o
);
    // loop each bit back unchanged, or force continuous zeros
    assign rxd_o = brk_i ? 1'b0 : txd_i;
endmodule : umsp_far_end

/* bench/umsp_uart_properties.sv */
// bus, frame and pin timing checks of the serial port
`timescale 1ns/1ns
module umsp_uart_properties (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire umsp_pkg::umsp_avs_req_t avs_req_i,
    input wire umsp_pkg::umsp_avs_rsp_t avs_rsp_o,
    input wire logic cts_n_i,
    input wire logic txd_o,
    input wire logic rts_n_o,
    input wire logic gpio_o,
    input wire logic gpio_oe_o,
    input wire logic event_req_o
);
    import umsp_pkg::*;
    logic [15:0] ctrl;
    logic [7:0] hi_cnt;
    logic wr_ok;
    logic [15:0] wd;
    assign wr_ok = avs_req_i.write && !avs_rsp_o.waitrequest;
    assign wd = avs_req_i.writedata[15:0];
    // shadow control word and length of the current high run on txd
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl <= CTRL_RST;
            hi_cnt <= 8'h00;
        end else begin
            if (wr_ok && avs_req_i.address == REG_CTRL) begin
                ctrl <= wd;
            end
            hi_cnt <= !txd_o ? 8'h00 : (hi_cnt == 8'hff ? hi_cnt : hi_cnt + 8'h01);
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    property p_wait_one;
        $fell(avs_rsp_o.waitrequest) |=> avs_rsp_o.waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("long wait low");
    property p_wait_cause;
        !avs_rsp_o.waitrequest |-> $past(avs_req_i.read || avs_req_i.write);
    endproperty
    a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
    property p_rd_upper;
        !avs_rsp_o.waitrequest |-> avs_rsp_o.readdata[31:16] == 16'h0000;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
    property p_bit_hold;
        !ctrl[C_IR] && $fell(txd_o) |=> !txd_o [*8];
    endproperty
    a_bit_hold: assert property (p_bit_hold) else $error("short low bit");
    property p_ir_pulse;
        ctrl[C_IR] && !ctrl[C_IR_INV] && $rose(txd_o) |-> txd_o [*3] ##1 !txd_o;
    endproperty
    a_ir_pulse: assert property (p_ir_pulse) else $error("bad pulse width");
    property p_cts_block;
        (cts_n_i [*8]) ##0 (hi_cnt > 8'hb4 && ctrl[2:0] == 3'h7 && ctrl[10:9] == 2'h0
            && !ctrl[C_IR]) |=> txd_o;
    endproperty
    a_cts_block: assert property (p_cts_block) else $error("sent while blocked");
    property p_rts_reset;
        $rose(rstn_i) |=> !rts_n_o;
    endproperty
    a_rts_reset: assert property (p_rts_reset) else $error("rts not ready");
    property p_evt_mask;
        ctrl[12:11] == 2'h0 && $past(ctrl[12:11]) == 2'h0 |-> !event_req_o;
    endproperty
    a_evt_mask: assert property (p_evt_mask) else $error("masked event");
    property p_aux_out;
        wr_ok && avs_req_i.address == REG_BAUD && wd[14:12] == 3'h5
            |-> ##[1:3] gpio_oe_o && gpio_o;
    endproperty
    a_aux_out: assert property (p_aux_out) else $error("aux level missing");
    property p_rts_sw;
        wr_ok && avs_req_i.address == REG_RX && wd[15:14] == 2'h3 |-> ##[1:3] rts_n_o;
    endproperty
    a_rts_sw: assert property (p_rts_sw) else $error("rts level missing");
endmodule : umsp_uart_properties
bind umsp_uart umsp_uart_properties u_umsp_uart_properties (.clk_i(clk_i), .rstn_i(rstn_i),
    .avs_req_i(avs_req_i), .avs_rsp_o(avs_rsp_o), .cts_n_i(cts_n_i), .txd_o(txd_o),
    .rts_n_o(rts_n_o), .gpio_o(gpio_o), .gpio_oe_o(gpio_oe_o), .event_req_o(event_req_o));

/* bench/testbench.sv */
// self-checking bench of the serial port block
`timescale 1ns/1ns
module testbench;
    import umsp_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic cts_n = 1'b0;
    logic brk = 1'b0;
    logic gpio_ext = 1'b0;
    logic rxd, txd, rts_n, gpio_o, gpio_oe, evt, pin;
    umsp_avs_req_t req = '0;
    umsp_avs_rsp_t rsp;
    int n_mismatch = 0;
    int total_checks = 0;
    logic [15:0] rdat;
    logic [11:0] got, exp_f;
    logic [23:0] rows [5] = '{24'h024741, 24'h0257a5, 24'h027741, 24'h02175b, 24'h02077e};
    // ----------------------------------------
    // clock, resolved gpio wire, instances
    // ----------------------------------------
    always #5 clk_i = ~clk_i;
    assign pin = gpio_oe ? gpio_o : gpio_ext;
    umsp_uart u_umsp_uart (.clk_i(clk_i), .rstn_i(rstn_i), .avs_req_i(req), .avs_rsp_o(rsp),
        .rxd_i(rxd), .cts_n_i(cts_n), .gpio_i(pin), .txd_o(txd), .rts_n_o(rts_n),
        .gpio_o(gpio_o), .gpio_oe_o(gpio_oe), .event_req_o(evt));
    umsp_far_end u_umsp_far_end (.txd_i(txd), .brk_i(brk), .rxd_o(rxd));
    // verdict and end of run
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check
    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [2:0] a, input logic [15:0] d);
        int k;
        @(posedge clk_i);
        req.read <= !wr;
        req.write <= wr;
        req.address <= a;
        req.writedata <= {16'h0000, d};
        for (k = 0; k < 20 && rsp.waitrequest !== 1'b0; k++) @(posedge clk_i);
        rdat = rsp.readdata[15:0];
        req.read <= 1'b0;
        req.write <= 1'b0;
        if (k == 20) begin
            n_mismatch++;
            complete_run();
        end
    endtask : bus
    // sample n bits of a frame at mid bit after the start edge
    task automatic frame(input int n);
        int k;
        got = 12'hfff;
        for (k = 0; k < 600 && txd !== 1'b0; k++) @(posedge clk_i);
        if (k == 600) begin
            n_mismatch++;
            complete_run();
        end
        repeat (8) @(posedge clk_i);
        for (k = 0; k < n; k++) begin
            got[k] = txd;
            repeat (16) @(posedge clk_i);
        end
    endtask : frame
    // main sequence: format table, then flow, infra-red, break, pins, reset
    initial begin
        int i;
        int k;
        int n;
        logic [23:0] r;
        repeat (12) @(posedge clk_i);
        rstn_i <= 1'b1;
        bus(1'b1, REG_BAUD, 16'h0000);
        for (i = 0; i < 5; i++) begin
            r = rows[i];
            n = r[14] ? 8 : 7;
            exp_f = 12'hfff;
            exp_f[0] = 1'b0;
            for (k = 0; k < n; k++) exp_f[k+1] = r[k];
            exp_f[n+1] = r[12] ? (^r[7:0]) ^ r[13] : 1'b1;
            bus(1'b1, REG_CTRL, r[23:8]);
            bus(1'b1, REG_TX, {8'h00, r[7:0]});
            frame(n + 2 + int'(r[12]));
            check({4'h0, got}, {4'h0, exp_f});
            repeat (8) @(posedge clk_i);
            bus(1'b0, REG_RX, 16'h0000);
            check(rdat, {8'h10, r[7:0]});
            $display("row %0d done", i);
        end
        bus(1'b1, REG_CTRL, 16'h0847);
        cts_n <= 1'b1;
        repeat (8) @(posedge clk_i);
        bus(1'b1, REG_TX, 16'h0055);
        n = 0;
        for (k = 0; k < 300; k++) begin
            @(posedge clk_i);
            n += int'(txd === 1'b0);
        end
        check(n[15:0], 16'h0000);
        check({15'h0, evt}, 16'h0001);
        bus(1'b0, REG_FLOW, 16'h0000);
        check(rdat, 16'h0003);
        bus(1'b1, REG_FLOW, 16'h0002);
        repeat (2) @(posedge clk_i);
        check({15'h0, evt}, 16'h0000);
        cts_n <= 1'b0;
        frame(10);
        check({4'h0, got}, 16'h0eaa);
        repeat (8) @(posedge clk_i);
        bus(1'b0, REG_RX, 16'h0000);
        check(rdat, 16'h1055);
        $display("flow test done");
        bus(1'b1, REG_CTRL, 16'h02c7);
        repeat (4) @(posedge clk_i);
        check({15'h0, txd}, 16'h0000);
        bus(1'b1, REG_TX, 16'h0000);
        n = 0;
        for (k = 0; k < 240; k++) begin
            @(posedge clk_i);
            n += int'(txd === 1'b1);
        end
        check(n[15:0], 16'h001b);
        bus(1'b0, REG_RX, 16'h0000);
        check(rdat, 16'h1000);
        bus(1'b1, REG_CTRL, 16'h0247);
        repeat (24) @(posedge clk_i);
        bus(1'b1, REG_CTRL, 16'h03c7);
        bus(1'b1, REG_TX, 16'h0000);
        n = 0;
        for (k = 0; k < 240; k++) begin
            @(posedge clk_i);
            n += int'(txd === 1'b0);
        end
        check(n[15:0], 16'h001b);
        bus(1'b0, REG_RX, 16'h0000);
        check(rdat, 16'h1000);
        $display("infra-red test done");
        bus(1'b1, REG_CTRL, 16'h0247);
        brk <= 1'b1;
        repeat (170) @(posedge clk_i);
        brk <= 1'b0;
        repeat (40) @(posedge clk_i);
        bus(1'b0, REG_RX, 16'h0000);
        check(rdat, 16'h1600);
        bus(1'b1, REG_CTRL, 16'h1247);
        gpio_ext <= 1'b1;
        repeat (8) @(posedge clk_i);
        check({15'h0, evt}, 16'h0001);
        bus(1'b0, REG_FLOW, 16'h0000);
        check(rdat, 16'h000e);
        bus(1'b1, REG_RX, 16'hc000);
        bus(1'b1, REG_BAUD, 16'h5000);
        repeat (3) @(posedge clk_i);
        check({13'h0, rts_n, gpio_oe, gpio_o}, 16'h0007);
        bus(1'b0, 3'h5, 16'h0000);
        check(rdat, 16'h0000);
        $display("break and pin test done");
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check({13'h0, txd, gpio_oe, evt}, 16'h0004);
        rstn_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        check({15'h0, rts_n}, 16'h0000);
        bus(1'b0, REG_CTRL, 16'h0000);
        check(rdat, CTRL_RST);
        $display("reset test done");
        complete_run();
    end
endmodule : testbench
